// file: src/adc_port_pkg.sv
// Shared constants, field layouts and state types of the converter serial control port
`default_nettype none
package adc_port_pkg;

	// ---------------------------------------------------------------
	// Word and register geometry
	// ---------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int DATA_W = 14;
	localparam int RES_W = 12;
	localparam int CAL_REGS = 10;
	localparam int BC_W = $clog2(WORD_W + 1);
	localparam int PTR_W = $clog2(CAL_REGS);
	localparam int TICK_W = 16;

	// ---------------------------------------------------------------
	// Write address, read select, calibration select and power management codes
	// ---------------------------------------------------------------
	localparam logic [1:0] ADDR_NONE = 2'h0;
	localparam logic [1:0] ADDR_TEST = 2'h1;
	localparam logic [1:0] ADDR_CAL = 2'h2;
	localparam logic [1:0] ADDR_CTRL = 2'h3;
	localparam logic [1:0] RD_RESULT = 2'h0;
	localparam logic [1:0] RD_TEST = 2'h1;
	localparam logic [1:0] RD_CAL = 2'h2;
	localparam logic [1:0] RD_STATUS = 2'h3;
	localparam logic [1:0] CALSEL_FULL = 2'h0;
	localparam logic [1:0] PMGT_NORMAL = 2'h0;
	localparam logic [1:0] PMGT_FULL_DOWN = 2'h1;
	localparam logic [1:0] PMGT_AUTO_DOWN = 2'h2;

	// ---------------------------------------------------------------
	// Serial mode pin codes {select_b, select_a}
	// ---------------------------------------------------------------
	localparam logic [1:0] SM_SELF_FOUT = 2'h0;
	localparam logic [1:0] SM_SELF_FIN = 2'h1;
	localparam logic [1:0] SM_EXT_BIDIR = 2'h2;
	localparam logic [1:0] SM_EXT = 2'h3;

	// ---------------------------------------------------------------
	// Default tick counts, in master clock rising edges; serial clock half period in system clock cycles
	// ---------------------------------------------------------------
	localparam int CONV_TICKS_DEF = 18;
	localparam int CAL_FULL_TICKS_DEF = 3000;
	localparam int CAL_PART_TICKS_DEF = 200;
	localparam int SCLK_HALF_DEF = 4;

	// ---------------------------------------------------------------
	// Field layouts
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [3:0] zero;
		logic [1:0] pmgt;
		logic [1:0] rdslt;
		logic bidir;
		logic soft_conv;
		logic cal_mode;
		logic [1:0] cal_sel;
		logic start_cal;
	} ctrl_t;
	localparam ctrl_t CTRL_RESET = '0;

	typedef struct packed {
		logic [6:0] spare;
		logic [1:0] pmgt;
		logic [1:0] rdslt;
		logic cal_done;
		logic converting;
		logic busy;
	} status_t;

	typedef struct packed {
		logic [1:0] addr;
		logic [DATA_W-1:0] data;
	} wr_word_t;

	typedef struct packed {
		logic sleep_n;
		logic mode_b;
		logic mode_a;
		logic idle_high;
		logic master_clk;
		logic conv_trig;
		logic cal_n;
		logic din;
		logic frame_n;
		logic sclk;
	} pins_t;
	localparam int PIN_W = $bits(pins_t);
	localparam pins_t PINS_RESET = '{sleep_n: 1'h1, cal_n: 1'h1, frame_n: 1'h1, conv_trig: 1'h1,
		default: 1'h0};

	typedef struct packed {
		logic self_clk;
		logic frame_out;
		logic bidir_ok;
	} ser_cfg_t;

	// ---------------------------------------------------------------
	// State encodings
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		MODE_SELF_FOUT = 4'h1,
		MODE_SELF_FIN = 4'h2,
		MODE_EXT_BIDIR = 4'h4,
		MODE_EXT = 4'h8
	} ser_mode_t;
	typedef enum logic [1:0] {SER_IDLE = 2'h1, SER_RUN = 2'h2} ser_st_t;
	typedef enum logic [2:0] {CV_IDLE = 3'h1, CV_CONV = 3'h2, CV_CAL = 3'h4} cv_st_t;

endpackage : adc_port_pkg
`default_nettype wire

// file: src/pin_sync.sv
// Two-flop synchroniser with edge detection for a group of pins
`default_nettype none
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// Pins
	input wire logic [W-1:0] i_async,
	// Synchronised level and edges
	output logic [W-1:0] o_level,
	output logic [W-1:0] o_rise,
	output logic [W-1:0] o_fall
);
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic meta_r, meta_nxt, sync_r, sync_nxt, hist_r, hist_nxt;
			always_comb begin
				meta_nxt = i_async[g];
				sync_nxt = meta_r;
				hist_nxt = sync_r;
			end
			always_ff @(posedge i_sys_clk) begin
				if (i_sys_rst) begin
					meta_r <= RST_VAL[g];
					sync_r <= RST_VAL[g];
					hist_r <= RST_VAL[g];
				end else begin
					meta_r <= meta_nxt;
					sync_r <= sync_nxt;
					hist_r <= hist_nxt;
				end
			end
			// Edges look only at the second stage and its history
			assign o_level[g] = sync_r;
			assign o_rise[g] = sync_r & ~hist_r;
			assign o_fall[g] = ~sync_r & hist_r;
		end
	endgenerate
endmodule : pin_sync
`default_nettype wire

// file: src/adc_serial_control_port.sv
// Serial control port and conversion/calibration sequencer of a sampling converter
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`default_nettype none
module adc_serial_control_port import adc_port_pkg::*; #(
	parameter int CONV_TICKS = CONV_TICKS_DEF,
	parameter int CAL_FULL_TICKS = CAL_FULL_TICKS_DEF,
	parameter int CAL_PART_TICKS = CAL_PART_TICKS_DEF,
	parameter int SCLK_HALF = SCLK_HALF_DEF
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// Mode and control pins
	input wire logic i_serial_mode_select_a,
	input wire logic i_serial_mode_select_b,
	input wire logic i_sclk_idle_high,
	input wire logic i_calibrate_n,
	input wire logic i_conversion_trigger_pin,
	input wire logic i_master_clock_in,
	input wire logic i_sleep_n,
	// Serial clock pin
	input wire logic i_sclk,
	output logic o_sclk,
	output logic o_sclk_oe,
	// Frame pin
	input wire logic i_frame_n,
	output logic o_frame_n,
	output logic o_frame_oe,
	// Data pins
	input wire logic i_din,
	output logic o_din,
	output logic o_din_oe,
	output logic o_dout,
	// Converter core
	input wire logic [RES_W-1:0] i_conv_result,
	output logic o_hold,
	output logic o_busy,
	output logic o_cal_run,
	output logic o_power_down
);

	// ---------------------------------------------------------------
	// Parameter checks
	// ---------------------------------------------------------------
	if (CONV_TICKS < 1 || CAL_FULL_TICKS < 1 || CAL_PART_TICKS < 1 || SCLK_HALF < 1 ||
			CAL_FULL_TICKS > (1 << TICK_W) || CAL_PART_TICKS > (1 << TICK_W) ||
			CONV_TICKS > (1 << TICK_W) || SCLK_HALF > (1 << TICK_W)) begin : g_bad_param
		$error("adc_serial_control_port: tick counts out of range");
	end

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	pins_t pin_raw, pin_lvl, pin_rise, pin_fall;
	assign pin_raw = '{sleep_n: i_sleep_n, mode_b: i_serial_mode_select_b,
		mode_a: i_serial_mode_select_a, idle_high: i_sclk_idle_high,
		master_clk: i_master_clock_in, conv_trig: i_conversion_trigger_pin,
		cal_n: i_calibrate_n, din: i_din, frame_n: i_frame_n, sclk: i_sclk};

	// Calibration pin history resets high so a tied-high pin gives no rise
	pin_sync #(.W(PIN_W), .RST_VAL(PINS_RESET)) u_pin_sync (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(pin_raw),
		.o_level(pin_lvl),
		.o_rise(pin_rise),
		.o_fall(pin_fall)
	);

	// ---------------------------------------------------------------
	// Mode decode
	// ---------------------------------------------------------------
	ser_mode_t mode;
	ser_cfg_t cfg;
	always_comb begin
		unique case ({pin_lvl.mode_b, pin_lvl.mode_a})
			SM_SELF_FOUT: mode = MODE_SELF_FOUT;
			SM_SELF_FIN: mode = MODE_SELF_FIN;
			SM_EXT_BIDIR: mode = MODE_EXT_BIDIR;
			SM_EXT: mode = MODE_EXT;
		endcase
		cfg.self_clk = (mode == MODE_SELF_FOUT) || (mode == MODE_SELF_FIN);
		cfg.frame_out = (mode == MODE_SELF_FOUT);
		cfg.bidir_ok = (mode == MODE_EXT_BIDIR);
	end

	// ---------------------------------------------------------------
	// State declarations
	// ---------------------------------------------------------------
	ser_st_t ser_r, ser_nxt;
	logic [BC_W-1:0] bitcnt_r, bitcnt_nxt;
	logic [WORD_W-2:0] shin_r, shin_nxt;
	logic [WORD_W-1:0] shout_r, shout_nxt;
	logic bidir_frame_r, bidir_frame_nxt;
	logic [TICK_W-1:0] div_r, div_nxt;
	logic sclk_gen_r, sclk_gen_nxt;
	logic frame_out_r, frame_out_nxt;
	logic rdy_pend_r, rdy_pend_nxt;
	ctrl_t ctrl_r, ctrl_nxt;
	logic [DATA_W-1:0] test_r, test_nxt;
	logic [DATA_W-1:0] cal_r [CAL_REGS];
	logic [DATA_W-1:0] cal_nxt [CAL_REGS];
	logic [PTR_W-1:0] ptr_r, ptr_nxt;
	cv_st_t cv_r, cv_nxt;
	logic [TICK_W-1:0] tick_r, tick_nxt;
	logic cal_full_r, cal_full_nxt;
	logic cal_done_r, cal_done_nxt;
	logic [RES_W-1:0] result_r, result_nxt;

	logic running, toggle, lead, trail, start, stop, wr_pulse, conv_done;
	wr_word_t wr_word;
	ctrl_t wr_ctrl;
	status_t status;
	logic [WORD_W-1:0] rd_word;

	// ---------------------------------------------------------------
	// Serial engine
	// ---------------------------------------------------------------
	assign running = (ser_r == SER_RUN);
	assign toggle = running && cfg.self_clk && (div_r == TICK_W'(SCLK_HALF - 1));

	always_comb begin
		// Leading edge leaves the idle level, trailing edge returns to it
		if (cfg.self_clk) begin
			lead = toggle && (sclk_gen_r == pin_lvl.idle_high);
			trail = toggle && (sclk_gen_r != pin_lvl.idle_high);
		end else begin
			lead = running && (pin_lvl.idle_high ? pin_fall.sclk : pin_rise.sclk);
			trail = running && (pin_lvl.idle_high ? pin_rise.sclk : pin_fall.sclk);
		end
		if (cfg.frame_out) begin
			start = !running && rdy_pend_r;
		end else begin
			start = !running && pin_fall.frame_n;
		end
		stop = running && ((cfg.self_clk && trail && bitcnt_r == BC_W'(WORD_W)) ||
			(!cfg.frame_out && pin_rise.frame_n));
		wr_pulse = lead && !bidir_frame_r && (bitcnt_r == BC_W'(WORD_W - 1));
		wr_word = {shin_r, pin_lvl.din};
		wr_ctrl = ctrl_t'(wr_word.data);
	end

	always_comb begin
		ser_nxt = ser_r;
		bitcnt_nxt = bitcnt_r;
		shin_nxt = shin_r;
		shout_nxt = shout_r;
		bidir_frame_nxt = bidir_frame_r;
		div_nxt = '0;
		sclk_gen_nxt = pin_lvl.idle_high;
		frame_out_nxt = 1'h1;
		rdy_pend_nxt = rdy_pend_r;
		if (start) begin
			ser_nxt = SER_RUN;
			bitcnt_nxt = '0;
			shin_nxt = '0;
			shout_nxt = rd_word;
			bidir_frame_nxt = cfg.bidir_ok && ctrl_r.bidir;
			rdy_pend_nxt = 1'h0;
			frame_out_nxt = 1'h0;
		end else if (running) begin
			frame_out_nxt = 1'h0;
			sclk_gen_nxt = toggle ? ~sclk_gen_r : sclk_gen_r;
			div_nxt = toggle ? '0 : div_r + TICK_W'(1);
			if (lead && bitcnt_r != BC_W'(WORD_W)) begin
				shin_nxt = wr_word[WORD_W-2:0];
				bitcnt_nxt = bitcnt_r + BC_W'(1);
			end
			if (trail) begin
				shout_nxt = {shout_r[WORD_W-2:0], 1'h0};
			end
			if (stop) begin
				ser_nxt = SER_IDLE;
				bitcnt_nxt = '0;
				bidir_frame_nxt = 1'h0;
				frame_out_nxt = 1'h1;
				sclk_gen_nxt = pin_lvl.idle_high;
			end
		end
		// A new result arriving with the frame start is kept for the next frame
		if (conv_done) begin
			rdy_pend_nxt = 1'h1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			ser_r <= SER_IDLE;
			bitcnt_r <= '0;
			shin_r <= '0;
			shout_r <= '0;
			bidir_frame_r <= 1'h0;
			div_r <= '0;
			sclk_gen_r <= 1'h0;
			frame_out_r <= 1'h1;
			rdy_pend_r <= 1'h0;
		end else begin
			ser_r <= ser_nxt;
			bitcnt_r <= bitcnt_nxt;
			shin_r <= shin_nxt;
			shout_r <= shout_nxt;
			bidir_frame_r <= bidir_frame_nxt;
			div_r <= div_nxt;
			sclk_gen_r <= sclk_gen_nxt;
			frame_out_r <= frame_out_nxt;
			rdy_pend_r <= rdy_pend_nxt;
		end
	end

	assign o_sclk = sclk_gen_r;
	assign o_sclk_oe = cfg.self_clk;
	assign o_frame_n = frame_out_r;
	assign o_frame_oe = cfg.frame_out;
	assign o_dout = shout_r[WORD_W-1];
	assign o_din = shout_r[WORD_W-1];
	// Driver only inside a bidirectional frame, dropped at the frame end
	assign o_din_oe = running && bidir_frame_r;

	// ---------------------------------------------------------------
	// Register file
	// ---------------------------------------------------------------
	assign status = '{spare: '0, pmgt: ctrl_r.pmgt, rdslt: ctrl_r.rdslt,
		cal_done: cal_done_r, converting: o_hold, busy: o_busy};

	always_comb begin
		unique case (ctrl_r.rdslt)
			RD_RESULT: rd_word = WORD_W'(result_r);
			RD_TEST: rd_word = WORD_W'(test_r);
			RD_CAL: rd_word = WORD_W'(cal_r[ptr_r]);
			RD_STATUS: rd_word = WORD_W'(status);
		endcase
	end

	always_comb begin
		ctrl_nxt = ctrl_r;
		test_nxt = test_r;
		cal_nxt = cal_r;
		ptr_nxt = ptr_r;
		if (start) begin
			// Bidirectional mode lasts one frame; writes are ignored inside it
			ctrl_nxt.bidir = 1'h0;
			if (ctrl_r.rdslt == RD_CAL) begin
				ptr_nxt = (ptr_r == PTR_W'(CAL_REGS - 1)) ? '0 : ptr_r + PTR_W'(1);
			end
		end
		if (wr_pulse) begin
			unique case (wr_word.addr)
				ADDR_NONE: ;
				ADDR_TEST: test_nxt = wr_word.data;
				ADDR_CAL: begin
					cal_nxt[ptr_r] = wr_word.data;
					ptr_nxt = (ptr_r == PTR_W'(CAL_REGS - 1)) ? '0 : ptr_r + PTR_W'(1);
				end
				ADDR_CTRL: begin
					ctrl_nxt = wr_ctrl;
					ptr_nxt = '0;
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			ctrl_r <= CTRL_RESET;
			test_r <= '0;
			cal_r <= '{default: '0};
			ptr_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
			test_r <= test_nxt;
			cal_r <= cal_nxt;
			ptr_r <= ptr_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Conversion and calibration sequencer
	// ---------------------------------------------------------------
	logic tick, cal_req, conv_req, wr_is_ctrl, full_down;
	always_comb begin
		tick = pin_rise.master_clk;
		wr_is_ctrl = wr_pulse && (wr_word.addr == ADDR_CTRL);
		full_down = (ctrl_r.pmgt == PMGT_FULL_DOWN);
		cal_req = pin_rise.cal_n || (wr_is_ctrl && wr_ctrl.start_cal);
		conv_req = !full_down && (pin_rise.conv_trig || (wr_is_ctrl && wr_ctrl.soft_conv));
	end

	always_comb begin
		cv_nxt = cv_r;
		tick_nxt = tick_r;
		cal_full_nxt = cal_full_r;
		cal_done_nxt = cal_done_r;
		result_nxt = result_r;
		conv_done = 1'h0;
		if (!pin_lvl.cal_n) begin
			cv_nxt = CV_IDLE;
			tick_nxt = '0;
			cal_done_nxt = 1'h0;
		end else if (cal_req) begin
			cv_nxt = CV_CAL;
			tick_nxt = '0;
			cal_done_nxt = 1'h0;
			cal_full_nxt = pin_rise.cal_n || (wr_ctrl.cal_sel == CALSEL_FULL);
		end else begin
			unique case (cv_r)
				CV_IDLE: begin
					if (conv_req) begin
						cv_nxt = CV_CONV;
						tick_nxt = '0;
					end
				end
				CV_CONV: begin
					if (tick && tick_r == TICK_W'(CONV_TICKS - 1)) begin
						cv_nxt = CV_IDLE;
						result_nxt = i_conv_result;
						conv_done = 1'h1;
					end else if (tick) begin
						tick_nxt = tick_r + TICK_W'(1);
					end
				end
				CV_CAL: begin
					if (tick && tick_r == TICK_W'((cal_full_r ? CAL_FULL_TICKS :
							CAL_PART_TICKS) - 1)) begin
						cv_nxt = CV_IDLE;
						cal_done_nxt = 1'h1;
					end else if (tick) begin
						tick_nxt = tick_r + TICK_W'(1);
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			cv_r <= CV_IDLE;
			tick_r <= '0;
			cal_full_r <= 1'h1;
			cal_done_r <= 1'h0;
			result_r <= '0;
		end else begin
			cv_r <= cv_nxt;
			tick_r <= tick_nxt;
			cal_full_r <= cal_full_nxt;
			cal_done_r <= cal_done_nxt;
			result_r <= result_nxt;
		end
	end

	assign o_busy = (cv_r != CV_IDLE);
	assign o_hold = (cv_r == CV_CONV);
	assign o_cal_run = (cv_r == CV_CAL);
	// Sleep pin works with no write at all; never powers down mid-sequence
	assign o_power_down = !o_busy && (!pin_lvl.sleep_n || full_down ||
		(ctrl_r.pmgt == PMGT_AUTO_DOWN));

endmodule : adc_serial_control_port
`default_nettype wire

// file: verification/adc_port_monitor.sv
// Concurrent checks on the ports of the converter serial control port
`default_nettype none
module adc_port_monitor #(
	parameter int CONV_TICKS = 18,
	parameter int CAL_FULL_TICKS = 3000,
	parameter int CAL_PART_TICKS = 200
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// Pins
	input wire logic i_serial_mode_select_a,
	input wire logic i_serial_mode_select_b,
	input wire logic i_sclk_idle_high,
	input wire logic i_calibrate_n,
	input wire logic i_conversion_trigger_pin,
	input wire logic i_sleep_n,
	// Outputs
	input wire logic o_sclk,
	input wire logic o_sclk_oe,
	input wire logic o_frame_n,
	input wire logic o_frame_oe,
	input wire logic o_din_oe,
	input wire logic o_hold,
	input wire logic o_busy,
	input wire logic o_cal_run,
	input wire logic o_power_down
);
	// Bench master clock is 20 system cycles a tick
	localparam int MCLK_CYC = 20;
	logic [11:0] cnt_r;
	logic [11:0] cnt_nxt;
	always_comb cnt_nxt = o_busy ? cnt_r + 12'h1 : 12'h0;
	always_ff @(posedge i_sys_clk) cnt_r <= i_sys_rst ? 12'h0 : cnt_nxt;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	sclk_dir_a: assert property ($stable(i_serial_mode_select_b)[*4] |-> o_sclk_oe == !i_serial_mode_select_b)
		else $error("serial clock direction wrong for mode");
	frame_dir_a: assert property (($stable(i_serial_mode_select_a) && $stable(i_serial_mode_select_b))[*4]
		|-> o_frame_oe == (!i_serial_mode_select_a && !i_serial_mode_select_b)) else $error("frame direction wrong");
	sclk_idle_a: assert property (($stable(i_sclk_idle_high) && o_sclk_oe && o_frame_n)[*5]
		|-> o_sclk == i_sclk_idle_high) else $error("serial clock not at idle level");
	hold_busy_a: assert property (o_hold |-> o_busy && !o_cal_run) else $error("hold outside busy");
	conv_len_a: assert property ($fell(o_hold) && i_calibrate_n |-> cnt_r >= (CONV_TICKS - 1) * MCLK_CYC
		&& cnt_r <= CONV_TICKS * MCLK_CYC + 8) else $error("conversion length wrong");
	cal_len_a: assert property ($fell(o_cal_run) |-> cnt_r >= (CAL_PART_TICKS - 1) * MCLK_CYC
		&& cnt_r <= CAL_FULL_TICKS * MCLK_CYC + 8) else $error("calibration length wrong");
	cal_low_a: assert property (!i_calibrate_n[*5] |-> !o_busy) else $error("busy while calibration pin low");
	cal_rise_a: assert property ($rose(i_calibrate_n) && !$past(i_calibrate_n, 4) && i_sleep_n
		|-> ##[2:6] o_cal_run) else $error("calibration did not start");
	conv_start_a: assert property ($rose(i_conversion_trigger_pin) && !o_busy && !o_power_down
		&& i_calibrate_n |-> ##[2:6] o_hold) else $error("conversion did not start");
	din_dir_a: assert property (o_din_oe |-> i_serial_mode_select_b && !i_serial_mode_select_a)
		else $error("data input driven outside bidirectional mode");
	sleep_down_a: assert property ((!i_sleep_n)[*4] ##0 !o_busy |-> o_power_down)
		else $error("sleep pin did not power down");
	cover property ($fell(o_hold));
	cover property ($rose(o_cal_run));
	cover property ($rose(o_din_oe));
	cover property ($fell(o_frame_n) && o_frame_oe);
endmodule : adc_port_monitor
bind adc_serial_control_port adc_port_monitor #(.CONV_TICKS(CONV_TICKS),
	.CAL_FULL_TICKS(CAL_FULL_TICKS), .CAL_PART_TICKS(CAL_PART_TICKS)) mon (
	.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_serial_mode_select_a(i_serial_mode_select_a),
	.i_serial_mode_select_b(i_serial_mode_select_b), .i_sclk_idle_high(i_sclk_idle_high),
	.i_calibrate_n(i_calibrate_n), .i_conversion_trigger_pin(i_conversion_trigger_pin),
	.i_sleep_n(i_sleep_n), .o_sclk(o_sclk), .o_sclk_oe(o_sclk_oe), .o_frame_n(o_frame_n),
	.o_frame_oe(o_frame_oe), .o_din_oe(o_din_oe), .o_hold(o_hold), .o_busy(o_busy),
	.o_cal_run(o_cal_run), .o_power_down(o_power_down));
`default_nettype wire

// file: verification/host_link_model.sv
// Serial master model that frames and clocks external-clock transfers
`default_nettype none
module host_link_model (
	// Clock
	input wire logic i_clk,
	// Link
	input wire logic i_idle_high,
	input wire logic i_dout,
	input wire logic i_release,
	output logic o_sclk,
	output logic o_frame_n,
	output logic o_din
);
	timeunit 1ns;
	timeprecision 100ps;
	logic bit_r = 1'b0;
	logic tog_r = 1'b0;
	initial o_sclk = 1'b0;
	initial o_frame_n = 1'b1;
	always @(posedge i_clk) tog_r <= ~tog_r;
	// Clock stands at idle level between frames
	always @(posedge i_clk) if (o_frame_n) o_sclk <= i_idle_high;
	// Released line shows a moving pattern inside a frame, never a held value
	assign o_din = (i_release && !o_frame_n) ? tog_r : bit_r;
	// Half period of 8 system cycles gives an 80 ns link clock
	task automatic xfer(input logic [15:0] wr, input int nbits, output logic [15:0] rd);
		logic [15:0] sh;
		sh = wr;
		rd = '0;
		@(posedge i_clk);
		o_frame_n <= 1'b0;
		bit_r <= sh[15];
		sh = sh << 1;
		repeat (8) @(posedge i_clk);
		for (int i = 0; i < nbits; i++) begin
			o_sclk <= ~i_idle_high;
			repeat (8) @(posedge i_clk);
			rd = {rd[14:0], i_dout};
			o_sclk <= i_idle_high;
			bit_r <= sh[15];
			sh = sh << 1;
			repeat (8) @(posedge i_clk);
		end
		bit_r <= 1'b0;
		o_frame_n <= 1'b1;
		repeat (8) @(posedge i_clk);
	endtask : xfer
endmodule : host_link_model
`default_nettype wire

// file: verification/adc_serial_control_port_tb.sv
// Self-checking bench of the converter serial control port
`default_nettype none
module adc_serial_control_port_tb import adc_port_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int MCLK_CYC = 20;
	localparam int CONV_T = 18;
	localparam int CAL_F = 20;
	localparam int CAL_P = 8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic mode_a = 1'b1;
	logic mode_b = 1'b1;
	logic idle_high = 1'b0;
	logic cal_n = 1'b0;
	logic trig = 1'b0;
	logic mclk = 1'b0;
	logic sleep_n = 1'b1;
	logic release_r = 1'b0;
	logic oe_seen = 1'b0;
	logic din_bad = 1'b0;
	logic [RES_W-1:0] result = 12'ha5c;
	logic h_sclk, h_frame_n, h_din, d_sclk, d_sclk_oe, d_frame_n, d_frame_oe, d_din, d_din_oe;
	logic d_dout, hold, busy, cal_run, pdown;
	wire logic sclk_w;
	wire logic frame_w;
	wire logic din_w;
	int errors = 0;
	int cmp_count = 0;
	int mcnt = 0;
	int bcnt = 0;
	assign sclk_w = d_sclk_oe ? d_sclk : h_sclk;
	assign frame_w = d_frame_oe ? d_frame_n : h_frame_n;
	assign din_w = d_din_oe ? d_din : h_din;
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) mcnt <= (mcnt == MCLK_CYC / 2 - 1) ? 0 : mcnt + 1;
	always @(posedge clk) if (mcnt == MCLK_CYC / 2 - 1) mclk <= ~mclk;
	always @(posedge clk) if (d_din_oe === 1'b1) oe_seen <= 1'b1;
	always @(posedge clk) if (d_din_oe === 1'b1 && din_w !== d_dout) din_bad <= 1'b1;
	// Whole length of the busy pulse, so a start seen late by a task still counts
	always @(posedge clk) bcnt <= (busy === 1'b1) ? bcnt + 1 : 0;
	adc_serial_control_port #(.CONV_TICKS(CONV_T), .CAL_FULL_TICKS(CAL_F), .CAL_PART_TICKS(CAL_P),
		.SCLK_HALF(4)) DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_serial_mode_select_a(mode_a),
		.i_serial_mode_select_b(mode_b), .i_sclk_idle_high(idle_high), .i_calibrate_n(cal_n),
		.i_conversion_trigger_pin(trig), .i_master_clock_in(mclk), .i_sleep_n(sleep_n),
		.i_sclk(sclk_w), .o_sclk(d_sclk), .o_sclk_oe(d_sclk_oe), .i_frame_n(frame_w),
		.o_frame_n(d_frame_n), .o_frame_oe(d_frame_oe), .i_din(din_w), .o_din(d_din),
		.o_din_oe(d_din_oe), .o_dout(d_dout), .i_conv_result(result), .o_hold(hold),
		.o_busy(busy), .o_cal_run(cal_run), .o_power_down(pdown));
	host_link_model host (.i_clk(clk), .i_idle_high(idle_high), .i_dout(d_dout),
		.i_release(release_r), .o_sclk(h_sclk), .o_frame_n(h_frame_n), .o_din(h_din));
	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic xfer(input logic [15:0] wr, output logic [15:0] rd);
		host.xfer(wr, 16, rd);
		cyc(4);
	endtask : xfer
	task automatic wait_busy();
		for (int i = 0; i < 30 && busy !== 1'b1; i++) cyc(1);
	endtask : wait_busy
	// Waits out busy and judges its whole length against a tick count
	task automatic busy_len(input string what, input int ticks);
		int n;
		n = 0;
		while (busy === 1'b1 && n < 3000) begin
			cyc(1);
			n++;
		end
		check(what, {15'h0, bcnt > (ticks - 1) * MCLK_CYC && bcnt <= ticks * MCLK_CYC}, 16'h1);
	endtask : busy_len
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		check("frame out", {15'h0, d_frame_n}, 16'h1);
		check("busy", {15'h0, busy}, 16'h0);
		check("din enable", {15'h0, d_din_oe}, 16'h0);
		@(posedge clk) sleep_n <= 1'b0;
		cyc(6);
		check("sleep down", {15'h0, pdown}, 16'h1);
		@(posedge clk) sleep_n <= 1'b1;
		cyc(6);
		check("awake", {15'h0, pdown}, 16'h0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_autocal();
		@(posedge clk) cal_n <= 1'b1;
		wait_busy();
		check("autocal run", {15'h0, cal_run}, 16'h1);
		busy_len("autocal length", CAL_F);
		$display("test autocal done");
	endtask : t_autocal
	task automatic t_conv();
		logic [15:0] rd;
		@(posedge clk) trig <= 1'b1;
		wait_busy();
		check("hold", {15'h0, hold}, 16'h1);
		busy_len("conversion length", CONV_T);
		@(posedge clk) trig <= 1'b0;
		xfer(16'h0000, rd);
		check("read result", rd, {4'h0, result});
		$display("test conversion done");
	endtask : t_conv
	task automatic t_regs();
		logic [15:0] rd;
		xfer(16'hc080, rd);
		for (int i = 0; i < 4; i++) xfer(16'h9234, rd);
		xfer(16'hc080, rd);
		host.xfer(16'hffff, 8, rd);
		cyc(4);
		xfer(16'h3fff, rd);
		check("cal register", rd, 16'h1234);
		xfer(16'h0000, rd);
		check("cal next", rd, 16'h0000);
		xfer(16'hc0c0, rd);
		xfer(16'h0000, rd);
		check("status", rd & 16'hfffb, 16'h0018);
		$display("test registers done");
	endtask : t_regs
	task automatic t_soft();
		logic [15:0] rd;
		logic [15:0] words [2] = '{16'hc003, 16'hc010};
		for (int i = 0; i < 2; i++) begin
			xfer(words[i], rd);
			wait_busy();
			check("soft cal", {15'h0, cal_run}, {15'h0, i == 0});
			check("soft conv", {15'h0, hold}, {15'h0, i == 1});
			busy_len("soft length", (i == 0) ? CAL_P : CONV_T);
		end
		$display("test soft start done");
	endtask : t_soft
	task automatic t_abort();
		@(posedge clk) trig <= 1'b1;
		wait_busy();
		cyc(30);
		@(posedge clk) cal_n <= 1'b0;
		cyc(8);
		check("abort", {15'h0, busy}, 16'h0);
		@(posedge clk) cal_n <= 1'b1;
		trig <= 1'b0;
		wait_busy();
		check("restart cal", {15'h0, cal_run}, 16'h1);
		busy_len("cal length", CAL_F);
		$display("test abort done");
	endtask : t_abort
	task automatic t_modes();
		for (int m = 3; m >= 0; m--) begin
			@(posedge clk) {mode_b, mode_a} <= 2'(m);
			cyc(5);
			check("sclk dir", {15'h0, d_sclk_oe}, {15'h0, m < 2});
			check("frame dir", {15'h0, d_frame_oe}, {15'h0, m == 0});
		end
		cyc(200);
		for (int p = 0; p < 2; p++) begin
			@(posedge clk) idle_high <= 1'(p);
			cyc(6);
			check("sclk idle", {15'h0, d_sclk}, 16'(p));
		end
		$display("test modes done");
	endtask : t_modes
	task automatic t_self();
		int tg;
		logic prev;
		logic [15:0] w;
		@(posedge clk) trig <= 1'b1;
		for (int i = 0; i < 2000 && d_frame_n !== 1'b0; i++) cyc(1);
		tg = 0;
		w = '0;
		prev = d_sclk;
		for (int i = 0; i < 160; i++) begin
			cyc(1);
			if (d_sclk !== prev && d_sclk !== idle_high) w = {w[14:0], d_dout};
			if (d_sclk !== prev) tg++;
			prev = d_sclk;
		end
		@(posedge clk) trig <= 1'b0;
		check("self toggles", 16'(tg), 16'd32);
		check("self word", w, {4'h0, result});
		check("self frame end", {14'h0, d_frame_n, d_sclk}, 16'h3);
		$display("test self clock done");
	endtask : t_self
	task automatic t_bidir();
		logic [15:0] rd;
		@(posedge clk) {mode_b, mode_a} <= 2'h2;
		cyc(6);
		xfer(16'hc020, rd);
		check("no drive yet", {15'h0, oe_seen}, 16'h0);
		@(posedge clk) release_r <= 1'b1;
		xfer(16'h0000, rd);
		check("bidir drive", {15'h0, oe_seen}, 16'h1);
		check("bidir din", {15'h0, din_bad}, 16'h0);
		check("bidir word", rd, {4'h0, result});
		check("released", {15'h0, d_din_oe}, 16'h0);
		$display("test bidir done");
	endtask : t_bidir
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test
	initial begin
		#200000;
		errors++;
		end_of_test();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		cyc(6);
		t_reset();
		t_autocal();
		t_conv();
		t_regs();
		t_soft();
		t_abort();
		t_modes();
		t_self();
		t_bidir();
		end_of_test();
	end
endmodule : adc_serial_control_port_tb
`default_nettype wire
